// >>> bench/add_and_branch_execute_bench.sv
// Self-checking bench for the add, AND and branch-on-carry execute block
`timescale 1ns/1ps
`include "exec_core_regs.svh"

module add_and_branch_execute_bench
   import exec_core_pkg::*;
;
   logic clock;
   logic resetn;
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   logic load_en;
   logic [20:0] word_addr;
   logic [15:0] load_word;
   logic [15:0] fetch_word;
   logic [31:0] rd;
   logic err;
   int bad_count;
   int n_checks;

   add_and_branch_execute i_dut (.clock(clock), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp));
   program_store i_prog (.clock(clock), .load_en(load_en), .word_addr(word_addr), .load_word(load_word),
      .fetch_word(fetch_word));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ==========================================
   // Reporting
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      bad_count++;
      $display("FAIL %s expected completion seen timeout", what);
      print_verdict();
   endtask

   // ==========================================
   // APB master
   // Answer taken at the rising edge that sees pready; request held until that edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge clock);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      while (!done) begin
         @(posedge clock);
         done = (apb_rsp.pready === 1'b1);
         rd = apb_rsp.prdata;
         err = apb_rsp.pslverr;
         n++;
         if (!done && n > 16) hang("apb answer");
      end
      apb_req <= '0;
   endtask

   task automatic wait_idle(output logic nop);
      int n;
      nop = 1'b0;
      n = 0;
      do begin
         apb(1'b0, `OFF_EXEC_STATE, 32'h0000_0000);
         if (rd[2:0] == 3'h5) nop = 1'b1;
         n++;
         if (n > 40) hang("execution");
      end while (rd !== 32'h0000_0000);
   endtask

   // ==========================================
   // Expected results
   function automatic void model(input logic [15:0] ins, input logic [7:0] a, input logic [7:0] m,
      input logic [4:0] s, input logic [20:0] pc, output logic [7:0] ea, output logic [7:0] em,
      output logic [4:0] es, output logic [20:0] epc, output logic taken);
      logic [8:0] sum;
      logic [7:0] r;
      ea = a;
      em = m;
      es = s;
      epc = pc + 21'h0_0002;
      taken = 1'b0;
      sum = {1'b0, a} + {1'b0, m} + {8'h00, s[0]};
      if (ins[15:10] == `OPC6_ADD_CARRY) begin
         es = {sum[7], (a[7] == m[7]) && (sum[7] != a[7]), sum[7:0] == 8'h00,
            ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, s[0]}) > 5'h0F, sum[8]};
         if (ins[9]) em = sum[7:0];
         else ea = sum[7:0];
      end else if (ins[15:10] == `OPC6_AND_REG || ins[15:8] == `OPC8_AND_LIT) begin
         r = a & ((ins[15:8] == `OPC8_AND_LIT) ? ins[7:0] : m);
         es[4] = r[7];
         es[2] = (r == 8'h00);
         if (ins[15:8] == `OPC8_AND_LIT || !ins[9]) ea = r;
         else em = r;
      end else if (ins[15:8] == `OPC8_BRANCH_CARRY && s[0]) begin
         taken = 1'b1;
         epc = pc + 21'h0_0002 + {{12{ins[7]}}, ins[7:0], 1'b0};
      end
   endfunction

   // ==========================================
   // One instruction with random bank and counter
   task automatic exec_case(input logic [15:0] ins, input logic [7:0] a, input logic [7:0] m,
      input logic [4:0] s);
      logic [3:0] bank;
      logic [20:0] pc;
      logic [11:0] maddr;
      logic [7:0] ea;
      logic [7:0] em;
      logic [4:0] es;
      logic [20:0] epc;
      logic taken;
      logic nop;
      bank = 4'($urandom);
      pc = {20'($urandom), 1'b0};
      // Access bank: low half in bank 0, high half in bank 15
      maddr = ins[8] ? {bank, ins[7:0]} : {{4{ins[7]}}, ins[7:0]};
      model(ins, a, m, s, pc, ea, em, es, epc, taken);
      apb(1'b1, `OFF_BANK, 32'(bank));
      apb(1'b1, `OFF_DMEM_ADDR, 32'(maddr));
      apb(1'b1, `OFF_DMEM_DATA, 32'(m));
      apb(1'b1, `OFF_ACC, 32'(a));
      apb(1'b1, `OFF_STATUS, 32'(s));
      apb(1'b1, `OFF_PROG_COUNTER, 32'(pc));
      @(posedge clock);
      load_en <= 1'b1;
      word_addr <= pc;
      load_word <= ins;
      @(posedge clock);
      load_en <= 1'b0;
      @(negedge clock);
      apb(1'b1, `OFF_INSTR, 32'(fetch_word));
      wait_idle(nop);
      check("nop phase", 32'(nop), 32'(taken));
      apb(1'b0, `OFF_ACC, 32'h0000_0000);
      check("acc", rd, 32'(ea));
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      check("status", rd, 32'(es));
      apb(1'b0, `OFF_PROG_COUNTER, 32'h0000_0000);
      check("counter", rd, 32'(epc));
      apb(1'b1, `OFF_DMEM_ADDR, 32'(maddr));
      apb(1'b0, `OFF_DMEM_DATA, 32'h0000_0000);
      check("memory", rd, 32'(em));
   endtask

   // ==========================================
   // Main sequence
   initial begin
      logic [7:0] offs [7];
      logic [15:0] ins;
      logic nop;
      offs = '{`OFF_INSTR, `OFF_ACC, `OFF_STATUS, `OFF_BANK, `OFF_PROG_COUNTER, `OFF_DMEM_ADDR, `OFF_EXEC_STATE};
      apb_req = '0;
      resetn = 1'b0;
      load_en = 1'b0;
      word_addr = 21'h0_0000;
      load_word = 16'h0000;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(44581));
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0000_0000);
         check("reset value", rd, 32'h0000_0000);
      end
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped read error", 32'(err), 32'h0000_0001);
      $display("test reset done");
      exec_case(16'h2110, 8'h4D, 8'h02, 5'h01);
      exec_case(16'h2380, 8'h7F, 8'h00, 5'h01);
      exec_case(16'h20C0, 8'hFF, 8'h00, 5'h1F);
      exec_case(16'h0B5F, 8'hA3, 8'h00, 5'h1B);
      exec_case(16'h1490, 8'h17, 8'hC2, 5'h0B);
      exec_case(16'h16F0, 8'h80, 8'h81, 5'h00);
      exec_case(16'hE280, 8'h00, 8'h00, 5'h01);
      exec_case(16'hE27F, 8'h00, 8'h00, 5'h1F);
      exec_case(16'hE205, 8'h00, 8'h00, 5'h1E);
      exec_case(16'h3000, 8'h5A, 8'h3C, 5'h15);
      $display("test corner cases done");
      for (int i = 0; i < 48; i++) begin
         case (i % 4)
            0: ins = {`OPC6_ADD_CARRY, 10'($urandom)};
            1: ins = {`OPC8_AND_LIT, 8'($urandom)};
            2: ins = {`OPC6_AND_REG, 10'($urandom)};
            default: ins = {`OPC8_BRANCH_CARRY, 8'($urandom)};
         endcase
         exec_case(ins, 8'($urandom), 8'($urandom), 5'($urandom));
      end
      $display("test random instructions done");
      apb(1'b1, `OFF_ACC, 32'h0000_00F0);
      apb(1'b1, `OFF_INSTR, 32'h0000_0B3C);
      apb(1'b1, `OFF_ACC, 32'h0000_0055);
      check("busy write error", 32'(err), 32'h0000_0001);
      wait_idle(nop);
      apb(1'b0, `OFF_ACC, 32'h0000_0000);
      check("acc after busy write", rd, 32'h0000_0030);
      $display("test busy write done");
      print_verdict();
   end
endmodule

// >>> bench/program_store.sv
// Program store model that holds the instruction words handed to the block
`timescale 1ns/1ps

module program_store (
   input wire logic clock,
   input wire logic load_en,
   input wire logic [20:0] word_addr,
   input wire logic [15:0] load_word,
   output logic [15:0] fetch_word
);
   // ==========================================
   // Word storage
   // One whole 16-bit word per even address; the odd bit never selects a half
   logic [15:0] words [256];

   always_ff @(posedge clock) begin
      if (load_en) begin
         words[word_addr[8:1]] <= load_word;
      end
   end

   assign fetch_word = words[word_addr[8:1]];
endmodule

// >>> design/add_and_branch_execute.sv
// Decode and execute of add-with-carry, the two AND forms and branch-on-carry, with APB access
//
// Operation
// - Add-with-carry sums acc, file, carry; five flags
// - Add destination bit: 0 acc, 1 memory
// - Access bit 0 access bank, 1 bank register
// - AND literal into acc in one cycle
// - AND register updates only negative and zero
// - AND register destination bit: 0 acc, 1 file
// - AND register: one word, four phases
// - Branch on carry only; flags untouched
// - Taken target is counter plus two plus twice offset
// - Taken branch two cycles, untaken one
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "exec_core_regs.svh"

module add_and_branch_execute
   import exec_core_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire apb_req_t apb_req,
   output apb_rsp_t apb_rsp
);

   // ==========================================
   // State
   exec_state_t state_reg;
   logic [1:0] nop_cnt_reg;
   logic [15:0] instr_reg;
   logic [7:0] accumulator_reg;
   status_flags_t flags_reg;
   logic [3:0] bank_select_reg;
   logic [20:0] program_counter_reg;
   logic [11:0] dmem_addr_reg;
   logic [7:0] operand_reg;
   logic [7:0] result_reg;
   status_flags_t flags_new_reg;
   logic take_reg;
   apb_rsp_t rsp_reg;
   logic [7:0] data_mem [0:4095];

   // ==========================================
   // Decode
   logic is_add_carry;
   logic is_and_reg;
   logic is_and_lit;
   logic is_branch_carry;
   logic is_reg_form;
   logic dest_file;
   logic [11:0] file_addr;
   logic [8:0] add_sum;
   logic [4:0] add_low;
   logic [7:0] add_low7;
   logic [7:0] and_res;
   logic busy;

   assign is_add_carry = instr_reg[15:10] == `OPC6_ADD_CARRY;
   assign is_and_reg = instr_reg[15:10] == `OPC6_AND_REG;
   assign is_and_lit = instr_reg[15:8] == `OPC8_AND_LIT;
   assign is_branch_carry = instr_reg[15:8] == `OPC8_BRANCH_CARRY;
   assign is_reg_form = is_add_carry | is_and_reg;
   assign dest_file = instr_reg[`FLD_DEST];
   assign busy = state_reg != ST_IDLE;

   // Access bank splits the 256 addresses between the lowest and highest banks
   always_comb begin
      if (instr_reg[`FLD_ACCESS]) begin
         file_addr = {bank_select_reg, instr_reg[7:0]};
      end else if (instr_reg[`FLD_ACCESS_SPLIT]) begin
         file_addr = {`ACCESS_BANK_HIGH, instr_reg[7:0]};
      end else begin
         file_addr = {`ACCESS_BANK_LOW, instr_reg[7:0]};
      end
   end

   // Carry into bit 7 xor carry out gives signed overflow
   assign add_sum = {1'b0, accumulator_reg} + {1'b0, operand_reg} + {8'h00, flags_reg.carry};
   assign add_low = {1'b0, accumulator_reg[3:0]} + {1'b0, operand_reg[3:0]} + {4'h0, flags_reg.carry};
   assign add_low7 = {1'b0, accumulator_reg[6:0]} + {1'b0, operand_reg[6:0]} + {7'h00, flags_reg.carry};
   assign and_res = is_and_lit ? (accumulator_reg & instr_reg[7:0]) : (accumulator_reg & operand_reg);

   // ==========================================
   // APB decode
   logic setup_ph;
   logic access_ok;
   logic wr_hit;
   logic addr_known;

   assign setup_ph = apb_req.psel & ~apb_req.penable;
   assign access_ok = apb_req.psel & apb_req.penable & rsp_reg.pready;
   always_comb begin
      unique case (apb_req.paddr)
         `OFF_INSTR, `OFF_ACC, `OFF_STATUS, `OFF_BANK, `OFF_PROG_COUNTER,
         `OFF_DMEM_ADDR, `OFF_DMEM_DATA, `OFF_EXEC_STATE: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   end
   // Writes during execution are refused so the running instruction sees stable state
   assign wr_hit = access_ok & apb_req.pwrite & addr_known & ~busy & ~rsp_reg.pslverr;

   // ==========================================
   // Phase sequencer: decode, read, process, write
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         nop_cnt_reg <= 2'h0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (wr_hit && apb_req.paddr == `OFF_INSTR) begin
                  state_reg <= ST_DECODE;
               end
            end
            ST_DECODE: state_reg <= ST_READ;
            ST_READ: state_reg <= ST_PROCESS;
            ST_PROCESS: state_reg <= ST_WRITE;
            ST_WRITE: begin
               nop_cnt_reg <= 2'h0;
               state_reg <= take_reg ? ST_NOP : ST_IDLE;
            end
            ST_NOP: begin
               nop_cnt_reg <= nop_cnt_reg + 2'h1;
               if (nop_cnt_reg == `NOP_LAST_PHASE) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Instruction and operand capture
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         instr_reg <= `INSTR_RST;
         operand_reg <= 8'h00;
      end else begin
         if (wr_hit && apb_req.paddr == `OFF_INSTR) begin
            instr_reg <= apb_req.pwdata[15:0];
         end
         if (state_reg == ST_READ) begin
            operand_reg <= is_reg_form ? data_mem[file_addr] : instr_reg[7:0];
         end
      end
   end

   // ==========================================
   // Process phase: result, new flags, branch decision
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         result_reg <= 8'h00;
         flags_new_reg <= `STATUS_RST;
         take_reg <= 1'b0;
      end else if (state_reg == ST_PROCESS) begin
         flags_new_reg <= flags_reg;
         take_reg <= is_branch_carry & flags_reg.carry;
         if (is_add_carry) begin
            result_reg <= add_sum[7:0];
            flags_new_reg.carry <= add_sum[8];
            flags_new_reg.half_carry_flag <= add_low[4];
            flags_new_reg.signed_excess_flag <= add_low7[7] ^ add_sum[8];
            flags_new_reg.negative <= add_sum[7];
            flags_new_reg.zero <= add_sum[7:0] == 8'h00;
         end else if (is_and_reg || is_and_lit) begin
            result_reg <= and_res;
            flags_new_reg.negative <= and_res[7];
            flags_new_reg.zero <= and_res == 8'h00;
         end else begin
            result_reg <= accumulator_reg;
         end
      end
   end

   // ==========================================
   // Architectural registers, write phase and software access
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         accumulator_reg <= `ACC_RST;
         flags_reg <= `STATUS_RST;
         bank_select_reg <= `BANK_RST;
         dmem_addr_reg <= `DMEM_ADDR_RST;
      end else if (state_reg == ST_WRITE) begin
         if (is_add_carry || is_and_reg || is_and_lit) begin
            flags_reg <= flags_new_reg;
         end
         if (is_and_lit || (is_reg_form && !dest_file)) begin
            accumulator_reg <= result_reg;
         end
      end else if (wr_hit) begin
         unique case (apb_req.paddr)
            `OFF_ACC: accumulator_reg <= apb_req.pwdata[7:0];
            `OFF_STATUS: flags_reg <= apb_req.pwdata[4:0];
            `OFF_BANK: bank_select_reg <= apb_req.pwdata[3:0];
            `OFF_DMEM_ADDR: dmem_addr_reg <= apb_req.pwdata[11:0];
            default: ;
         endcase
      end
   end

   // Data memory has no reset; only the write phase or an idle bus write touches it
   always_ff @(posedge clock) begin
      if (state_reg == ST_WRITE && is_reg_form && dest_file) begin
         data_mem[file_addr] <= result_reg;
      end else if (wr_hit && apb_req.paddr == `OFF_DMEM_DATA) begin
         data_mem[dmem_addr_reg] <= apb_req.pwdata[7:0];
      end
   end

   // Counter moves past the word at decode; a taken branch adds twice the offset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         program_counter_reg <= `PROG_COUNTER_RST;
      end else if (state_reg == ST_DECODE) begin
         program_counter_reg <= program_counter_reg + `PROG_STEP;
      end else if (state_reg == ST_WRITE && take_reg) begin
         program_counter_reg <= program_counter_reg + {{12{instr_reg[7]}}, instr_reg[7:0], 1'b0};
      end else if (wr_hit && apb_req.paddr == `OFF_PROG_COUNTER) begin
         program_counter_reg <= {apb_req.pwdata[20:1], 1'b0};
      end
   end

   // ==========================================
   // APB answer: one wait-free access phase after each setup
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rsp_reg <= '0;
      end else if (setup_ph) begin
         rsp_reg.pready <= 1'b1;
         rsp_reg.pslverr <= ~addr_known | (apb_req.pwrite & busy);
         rsp_reg.prdata <= 32'h0000_0000;
         if (!apb_req.pwrite) begin
            unique case (apb_req.paddr)
               `OFF_INSTR: rsp_reg.prdata <= {16'h0000, instr_reg};
               `OFF_ACC: rsp_reg.prdata <= {24'h00_0000, accumulator_reg};
               `OFF_STATUS: rsp_reg.prdata <= {27'h000_0000, flags_reg};
               `OFF_BANK: rsp_reg.prdata <= {28'h000_0000, bank_select_reg};
               `OFF_PROG_COUNTER: rsp_reg.prdata <= {11'h000, program_counter_reg};
               `OFF_DMEM_ADDR: rsp_reg.prdata <= {20'h0_0000, dmem_addr_reg};
               `OFF_DMEM_DATA: rsp_reg.prdata <= {24'h00_0000, data_mem[dmem_addr_reg]};
               `OFF_EXEC_STATE: rsp_reg.prdata <= {29'h0000_0000, state_reg};
               default: rsp_reg.prdata <= 32'h0000_0000;
            endcase
         end
      end else begin
         rsp_reg.pready <= 1'b0;
         rsp_reg.pslverr <= 1'b0;
      end
   end

   assign apb_rsp = rsp_reg;

   // ==========================================
   // Assertions
   sequence s_phases;
      state_reg == ST_READ ##1 state_reg == ST_PROCESS ##1 state_reg == ST_WRITE;
   endsequence

   sequence s_nop_tail;
      (state_reg == ST_NOP) [*4] ##1 state_reg == ST_IDLE;
   endsequence

   property p_add_to_acc;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_add_carry && !dest_file) |->
         ##4 accumulator_reg == 8'($past(accumulator_reg, 4) + operand_reg + {7'h00, $past(flags_reg.carry, 4)});
   endproperty
   a_add_to_acc: assert property (p_add_to_acc) else $error("add with carry wrong in acc");

   property p_add_carry_out;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_add_carry) |->
         ##4 flags_reg.carry == (({1'b0, $past(accumulator_reg, 4)} + {1'b0, operand_reg}
            + {8'h00, $past(flags_reg.carry, 4)}) > 9'h0FF);
   endproperty
   a_add_carry_out: assert property (p_add_carry_out) else $error("add carry out wrong");

   property p_file_dest_keeps_acc;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_reg_form && dest_file) |-> ##4 accumulator_reg == $past(accumulator_reg, 4);
   endproperty
   a_file_dest_keeps_acc: assert property (p_file_dest_keeps_acc) else $error("acc changed on file dest");

   property p_bank_pick;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_READ && is_reg_form) |=>
         operand_reg == data_mem[{(instr_reg[`FLD_ACCESS] ? bank_select_reg : {4{instr_reg[7]}}),
            instr_reg[7:0]}];
   endproperty
   a_bank_pick: assert property (p_bank_pick) else $error("bank selection wrong");

   property p_and_lit;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_and_lit) |=>
         s_phases ##1 (state_reg == ST_IDLE && accumulator_reg == ($past(accumulator_reg, 4) & instr_reg[7:0]));
   endproperty
   a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

   property p_and_flags;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && (is_and_reg || is_and_lit)) |->
         ##4 (flags_reg.carry == $past(flags_reg.carry, 4)
            && flags_reg.half_carry_flag == $past(flags_reg.half_carry_flag, 4)
            && flags_reg.signed_excess_flag == $past(flags_reg.signed_excess_flag, 4)
            && flags_reg.negative == result_reg[7] && flags_reg.zero == (result_reg == 8'h00));
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("and flags wrong");

   property p_and_reg_acc;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_and_reg && !dest_file) |=>
         s_phases ##1 accumulator_reg == ($past(accumulator_reg, 4) & operand_reg);
   endproperty
   a_and_reg_acc: assert property (p_and_reg_acc) else $error("and register to acc wrong");

   property p_branch_flags;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_branch_carry) |-> ##4 flags_reg == $past(flags_reg, 4);
   endproperty
   a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");

   property p_branch_taken;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_branch_carry && flags_reg.carry) |->
         ##4 (program_counter_reg == 21'($past(program_counter_reg, 4) + `PROG_STEP
            + {{12{instr_reg[7]}}, instr_reg[7:0], 1'b0})) ##0 s_nop_tail;
   endproperty
   a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong");

   property p_branch_untaken;
      @(posedge clock) disable iff (!resetn)
      (state_reg == ST_DECODE && is_branch_carry && !flags_reg.carry) |->
         ##4 (state_reg == ST_IDLE && program_counter_reg == 21'($past(program_counter_reg, 4) + `PROG_STEP));
   endproperty
   a_branch_untaken: assert property (p_branch_untaken) else $error("untaken branch wrong");

endmodule

// >>> design/exec_core_pkg.sv
// Types shared by the execute block: states, flags and the bus carriers
package exec_core_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DECODE = 3'h1,
      ST_READ = 3'h2,
      ST_PROCESS = 3'h3,
      ST_WRITE = 3'h4,
      ST_NOP = 3'h5
   } exec_state_t;

   typedef struct packed {
      logic negative;
      logic signed_excess_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } status_flags_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

// >>> design/exec_core_regs.svh
// Register offsets, reset values, field codes and phase counts of the execute block
`ifndef EXEC_CORE_REGS_SVH
`define EXEC_CORE_REGS_SVH

// ==========================================
// Register byte offsets
`define OFF_INSTR 8'h00
`define OFF_ACC 8'h04
`define OFF_STATUS 8'h08
`define OFF_BANK 8'h0C
`define OFF_PROG_COUNTER 8'h10
`define OFF_DMEM_ADDR 8'h14
`define OFF_DMEM_DATA 8'h18
`define OFF_EXEC_STATE 8'h1C

// ==========================================
// Reset values
`define ACC_RST 8'h00
`define STATUS_RST 5'h00
`define BANK_RST 4'h0
`define PROG_COUNTER_RST 21'h0_0000
`define DMEM_ADDR_RST 12'h000
`define INSTR_RST 16'h0000

// ==========================================
// Opcode fields: upper six bits for register forms, upper byte for the others
`define OPC6_ADD_CARRY 6'h08
`define OPC6_AND_REG 6'h05
`define OPC8_AND_LIT 8'h0B
`define OPC8_BRANCH_CARRY 8'hE2

// Instruction word fields
`define FLD_DEST 9
`define FLD_ACCESS 8
`define FLD_ACCESS_SPLIT 7
`define ACCESS_BANK_HIGH 4'hF
`define ACCESS_BANK_LOW 4'h0

// ==========================================
// Timing: idle phases after a taken branch, last index
`define NOP_LAST_PHASE 2'h3
`define PROG_STEP 21'h0_0002

`endif
